//--- rtl/mba_pkg.sv
package mba_pkg;

	// Number of flip-flops that every outside input passes before logic reads it.
	localparam int unsigned SYNC_STAGES = 2;

	// Bit positions of the outside inputs inside the synchronised vector.
	localparam int unsigned IN_BUS_CLK   = 0;
	localparam int unsigned IN_BUSY_N    = 1;
	localparam int unsigned IN_COMMON_REQUEST_LINE_N    = 2;
	localparam int unsigned IN_PRIO_N    = 3;
	localparam int unsigned IN_ANY       = 4;
	localparam int unsigned IN_LOCK_N    = 5;
	localparam int unsigned IN_INIT_N    = 6;
	localparam int unsigned IN_PROC_REQ  = 7;
	localparam int unsigned IN_PROC_HALT = 8;
	localparam int unsigned IN_TRANSFER_ACKNOWLEDGE      = 9;
	localparam int unsigned IN_WIDTH     = 10;

	// Values of the synchroniser stages after reset: the idle level of each input.
	// Active-low lines idle high, the bus clock idles low.
	localparam logic [IN_WIDTH-1:0] SYNC_RESET = 10'h06E;

	// Values after reset of the registered outputs.
	localparam logic BUS_REQUEST_RESET  = 1'b1;
	localparam logic PRIORITY_OUT_RESET = 1'b1;
	localparam logic ADDR_ENABLE_RESET  = 1'b1;
	localparam logic PULL_RESET         = 1'b0;

	typedef enum logic [1:0]
	{
		MBA_IDLE    = 2'b00,
		MBA_REQUEST = 2'b01,
		MBA_OWN     = 2'b10
	} mba_state_t;

endpackage : mba_pkg

//--- rtl/mba_sync.sv
`timescale 1ns/100ps
`default_nettype none

// Two-stage synchroniser, one chain per input bit.
module mba_sync
	import mba_pkg::*;
(
	input  wire logic                i_sys_clk,
	input  wire logic                i_reset,
	input  wire logic [IN_WIDTH-1:0] i_async,
	output var  logic [IN_WIDTH-1:0] o_sync
);

	logic [IN_WIDTH-1:0] meta;

	genvar g;
	generate
		for (g = 0; g < IN_WIDTH; g++)
		begin : g_bit
			always_ff @(posedge i_sys_clk or posedge i_reset)
			begin
				if (i_reset)
				begin
					meta[g]   <= SYNC_RESET[g];
					o_sync[g] <= SYNC_RESET[g];
				end
				else
				begin
					meta[g]   <= i_async[g];
					o_sync[g] <= meta[g];
				end
			end
		end
	endgenerate

endmodule : mba_sync

`default_nettype wire

//--- rtl/mba_edge.sv
`timescale 1ns/100ps
`default_nettype none

// Finds the falling edges of the synchronised bus clock.
module mba_edge
	import mba_pkg::*;
(
	input  wire logic i_sys_clk,
	input  wire logic i_reset,
	input  wire logic i_level,
	output var  logic o_fall
);

	logic prev;

	always_ff @(posedge i_sys_clk or posedge i_reset)
	begin
		if (i_reset)
			prev <= SYNC_RESET[IN_BUS_CLK];
		else
			prev <= i_level;
	end

	assign o_fall = prev & ~i_level;

endmodule : mba_edge

`default_nettype wire

//--- rtl/mba_arbiter.sv
// What this block does
// - Common request line is wired open drain; non-owners pull it low to ask.
// - Never pull the common request line while owning the shared bus.
// - Owner seeing a common request drops bus request and surrenders when allowed.
// - Common request tied low with surrender strap high: surrender after every cycle.
// - Outside initialize, all shared-bus signals are driven and sampled on the bus clock.
// - Bus request output goes low to ask for the shared bus.
// - Asserted priority input allows taking the bus at next bus clock fall.
// - Priority input means highest requester; its loss means a higher one won.
// - Priority output, active low, feeds the next lower arbiter's priority input.
// - Busy is open drain, low active; free bus taken by prioritised requester.
// - When finished, release busy so it floats high for others.
// - Without ownership, hold controller, latches and transceivers off the bus.
// - Processor waits until the bus is won, then address enable goes active.
// - Owner that lost priority hands over once its present cycle completes.
// - Lower priority arbiter may take the bus when no higher one uses it.
// - Without other requests, keep ownership until the processor halts.
// - Never surrender voluntarily except on halt; only requests force it off.
// - Surrender strap yields to lower priority requesters as if higher.
// - Surrender strap with common request: give up at cycle end, request high.
// - Asserted request lock blocks surrender to common request requesters.
// - Global initialize resets the arbiter; afterwards it owns nothing.
// - Address enable tells controller and latches when to float outputs.
`timescale 1ns/100ps
`default_nettype none

module mba_arbiter
	import mba_pkg::*;
(
	input  wire logic i_sys_clk,
	input  wire logic i_reset,
	input  wire logic i_bus_clk,
	input  wire logic i_busy_n,
	input  wire logic i_common_request_line_n,
	input  wire logic i_priority_in_n,
	input  wire logic i_surrender_to_any_strap,
	input  wire logic i_request_lock_in_n,
	input  wire logic i_init_n,
	input  wire logic i_proc_request,
	input  wire logic i_proc_halt,
	input  wire logic i_transfer_acknowledge,
	output var  logic o_bus_request_out_n,
	output var  logic o_priority_out_n,
	output var  logic o_busy_out,
	output var  logic o_busy_oe,
	output var  logic o_common_request_line_out,
	output var  logic o_common_request_line_oe,
	output var  logic o_address_enable_out_n
);

	logic [IN_WIDTH-1:0] raw_in;
	logic [IN_WIDTH-1:0] sync_in;
	logic                bclk_fall;
	mba_state_t          state;
	mba_state_t          next_state;
	logic                cycle_active;
	logic                next_cycle_active;

	// Every outside input is synchronised before any logic looks at it.
	assign raw_in[IN_BUS_CLK]   = i_bus_clk;
	assign raw_in[IN_BUSY_N]    = i_busy_n;
	assign raw_in[IN_COMMON_REQUEST_LINE_N]    = i_common_request_line_n;
	assign raw_in[IN_PRIO_N]    = i_priority_in_n;
	assign raw_in[IN_ANY]       = i_surrender_to_any_strap;
	assign raw_in[IN_LOCK_N]    = i_request_lock_in_n;
	assign raw_in[IN_INIT_N]    = i_init_n;
	assign raw_in[IN_PROC_REQ]  = i_proc_request;
	assign raw_in[IN_PROC_HALT] = i_proc_halt;
	assign raw_in[IN_TRANSFER_ACKNOWLEDGE]      = i_transfer_acknowledge;

	mba_sync u_sync
	(
		.i_sys_clk (i_sys_clk),
		.i_reset   (i_reset),
		.i_async   (raw_in),
		.o_sync    (sync_in)
	);

	mba_edge u_edge
	(
		.i_sys_clk (i_sys_clk),
		.i_reset   (i_reset),
		.i_level   (sync_in[IN_BUS_CLK]),
		.o_fall    (bclk_fall)
	);

	// Decoded, active-high views of the synchronised inputs.
	wire busy_free   = sync_in[IN_BUSY_N];
	wire common_request_line_active = ~sync_in[IN_COMMON_REQUEST_LINE_N];
	wire prio_active = ~sync_in[IN_PRIO_N];
	wire any_strap   = sync_in[IN_ANY];
	wire lock_active = ~sync_in[IN_LOCK_N];
	wire init_active = ~sync_in[IN_INIT_N];
	wire proc_req    = sync_in[IN_PROC_REQ];
	wire proc_halt   = sync_in[IN_PROC_HALT];
	wire transfer_acknowledge        = sync_in[IN_TRANSFER_ACKNOWLEDGE];

	wire own         = (state == MBA_OWN);
	wire at_boundary = ~cycle_active;

	// A common request may force the bus away only when the lock is off.
	// With the strap high it wins at any boundary; otherwise only while idle.
	wire common_request_line_yield  = common_request_line_active & ~lock_active & (any_strap | ~proc_req);
	wire lost_prio   = ~prio_active;
	wire must_yield  = at_boundary & (proc_halt | lost_prio | common_request_line_yield);
	wire may_take    = prio_active & busy_free;
	wire want_bus    = proc_req & ~proc_halt;

	// A transfer cycle runs from the first owned request until acknowledge.
	assign next_cycle_active = own & proc_req & ~transfer_acknowledge;

	always_comb
	begin
		next_state = state;
		if (init_active)
			next_state = MBA_IDLE;
		else if (bclk_fall)
		begin
			case (state)
				MBA_IDLE:
					if (want_bus)
						next_state = MBA_REQUEST;
				MBA_REQUEST:
					if (proc_halt)
						next_state = MBA_IDLE;
					else if (may_take)
						next_state = MBA_OWN;
				MBA_OWN:
					if (must_yield)
						next_state = MBA_IDLE;
				default:
					next_state = MBA_IDLE;
			endcase
		end
	end

	// The bus-facing outputs follow the next state so they change together.
	wire next_own       = (next_state == MBA_OWN);
	wire next_requester = (next_state == MBA_REQUEST);
	wire next_bus_request_out_n    = (next_state == MBA_IDLE);
	wire next_prio_o_n  = ~(prio_active & (next_state == MBA_IDLE));
	wire outputs_step   = bclk_fall | init_active;

	always_ff @(posedge i_sys_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			state        <= MBA_IDLE;
			cycle_active <= 1'b0;
		end
		else
		begin
			state        <= next_state;
			cycle_active <= next_cycle_active;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			o_bus_request_out_n      <= BUS_REQUEST_RESET;
			o_priority_out_n         <= PRIORITY_OUT_RESET;
			o_busy_oe                <= PULL_RESET;
			o_common_request_line_oe <= PULL_RESET;
			o_address_enable_out_n   <= ADDR_ENABLE_RESET;
		end
		else if (outputs_step)
		begin
			o_bus_request_out_n      <= next_bus_request_out_n;
			o_priority_out_n         <= next_prio_o_n;
			o_busy_oe                <= next_own;
			o_common_request_line_oe <= next_requester;
			o_address_enable_out_n   <= ~next_own;
		end
	end

	// Both open-drain lines only ever pull low.
	always_ff @(posedge i_sys_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			o_busy_out                <= PULL_RESET;
			o_common_request_line_out <= PULL_RESET;
		end
		else
		begin
			o_busy_out                <= PULL_RESET;
			o_common_request_line_out <= PULL_RESET;
		end
	end

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_reset);

	AST_NO_COMMON_REQUEST_LINE_WHILE_OWN:
	assert property (o_busy_oe |-> !o_common_request_line_oe)
	else $error("Common request pulled while owning the bus.");

	AST_TAKE_ON_FALL:
	assert property (state == MBA_REQUEST && bclk_fall && may_take && !init_active
		&& !proc_halt |=> state == MBA_OWN ##0 o_busy_oe ##0 !o_address_enable_out_n)
	else $error("Free bus with priority was not taken on the bus clock fall.");

	AST_ENABLE_ONLY_ON_FALL:
	assert property ($fell(o_address_enable_out_n) |-> $past(bclk_fall))
	else $error("Address enable went active away from a bus clock fall.");

	AST_HOLD_IN_CYCLE:
	assert property (own && cycle_active && !init_active |=> own && o_busy_oe)
	else $error("Bus released in the middle of a transfer cycle.");

	AST_HALT_RELEASE:
	assert property (own && bclk_fall && at_boundary && proc_halt && !init_active
		|=> state == MBA_IDLE ##0 !o_busy_oe ##0 o_bus_request_out_n)
	else $error("Halted processor did not give up the bus.");

	AST_NO_VOLUNTARY:
	assert property (own && !proc_halt && prio_active && !common_request_line_active && !init_active
		|=> own)
	else $error("Bus surrendered with no request and no halt.");

	AST_ANY_SURRENDER:
	assert property (own && bclk_fall && at_boundary && any_strap && common_request_line_active
		&& !lock_active && !init_active
		|=> state == MBA_IDLE ##0 o_bus_request_out_n)
	else $error("Surrender strap and common request did not free the bus.");

	AST_LOCK_HOLDS:
	assert property (own && lock_active && prio_active && !proc_halt && !init_active
		|=> own)
	else $error("Bus surrendered while the request lock was active.");

	AST_PRIORITY_LOSS:
	assert property (own && bclk_fall && at_boundary && !prio_active && !init_active
		|=> state == MBA_IDLE ##1 !o_busy_oe [*2])
	else $error("Owner kept the bus after losing priority.");

	AST_INIT_CLEARS:
	assert property (init_active |=> state == MBA_IDLE && !o_busy_oe
		&& o_address_enable_out_n)
	else $error("Initialize left the arbiter owning the bus.");

	AST_OFF_BUS_WITHOUT_OWN:
	assert property (!own |-> o_address_enable_out_n && !o_busy_oe)
	else $error("Bus drivers enabled without ownership.");

	AST_OUTPUTS_HOLD_REQ:
	assert property (!bclk_fall && !init_active
		|=> $stable(o_bus_request_out_n) && $stable(o_common_request_line_oe))
	else $error("Request outputs changed away from a bus clock fall.");

	AST_OUTPUTS_HOLD_BUS:
	assert property (!bclk_fall && !init_active |=> $stable(o_busy_oe)
		&& $stable(o_address_enable_out_n) && $stable(o_priority_out_n))
	else $error("Bus outputs changed away from a bus clock fall.");

	AST_REQUEST_ON_FALL:
	assert property (state == MBA_IDLE && bclk_fall && want_bus && !init_active
		|=> state == MBA_REQUEST ##0 !o_bus_request_out_n ##0 o_common_request_line_oe)
	else $error("Processor request did not raise a bus request.");

	AST_NO_TAKE_WITHOUT_PRIO:
	assert property (state == MBA_REQUEST && !prio_active
		|=> state != MBA_OWN)
	else $error("Bus taken without priority.");

	AST_NO_TAKE_WHEN_BUSY:
	assert property (state == MBA_REQUEST && !busy_free
		|=> !o_busy_oe)
	else $error("Bus taken while another master held busy.");

	AST_IDLE_NOT_STRAIGHT_TO_OWN:
	assert property (state == MBA_IDLE
		|=> state != MBA_OWN)
	else $error("Bus taken without a request step.");

	AST_PRIO_OUT_IDLE_ONLY:
	assert property (!o_priority_out_n
		|-> state == MBA_IDLE)
	else $error("Priority passed on while requesting or owning.");

	AST_PRIO_PASS:
	assert property (state == MBA_IDLE && bclk_fall && prio_active && !want_bus
		&& !init_active |=> !o_priority_out_n)
	else $error("Unused priority was not passed down the chain.");

	AST_PRIO_BLOCK:
	assert property (!prio_active && (bclk_fall || init_active)
		|=> o_priority_out_n)
	else $error("Priority passed on without holding it.");

	AST_RELEASE_AT_BOUNDARY:
	assert property ($fell(o_busy_oe) && !$past(init_active)
		|-> $past(at_boundary))
	else $error("Busy released inside a transfer cycle.");

	AST_SURRENDER_DROPS_REQUEST:
	assert property ($fell(o_busy_oe)
		|-> o_bus_request_out_n && o_address_enable_out_n)
	else $error("Surrender left the bus request or address enable active.");

	AST_AEN_MATCHES_BUSY:
	assert property (o_address_enable_out_n
		== !o_busy_oe)
	else $error("Address enable disagrees with bus ownership.");

	AST_STRAP_LOW_KEEPS:
	assert property (own && common_request_line_active && !any_strap && proc_req && prio_active
		&& !proc_halt && !init_active |=> own)
	else $error("Bus yielded to a lower request without the strap.");

	AST_HALT_STAYS_IDLE:
	assert property (state == MBA_IDLE && proc_halt
		|=> state == MBA_IDLE)
	else $error("Halted processor requested the bus.");

	AST_REQUEST_HALT_DROPS:
	assert property (state == MBA_REQUEST && bclk_fall && proc_halt && !init_active
		|=> state == MBA_IDLE ##0 o_bus_request_out_n)
	else $error("Request kept after the processor halted.");

	AST_COMMON_REQUEST_LINE_ONLY_REQUESTING:
	assert property (o_common_request_line_oe
		|-> state == MBA_REQUEST)
	else $error("Common request pulled while not requesting.");

	AST_BUS_REQUEST_OUT_MATCHES_STATE:
	assert property (o_bus_request_out_n
		== (state == MBA_IDLE))
	else $error("Bus request disagrees with the arbiter state.");

	AST_OWN_KEEPS_BUSY:
	assert property (own
		|-> o_busy_oe && !o_common_request_line_oe)
	else $error("Owner does not hold busy.");

	AST_CYCLE_ONLY_OWNED:
	assert property (cycle_active
		|-> $past(own))
	else $error("Transfer cycle counted without ownership.");

endmodule : mba_arbiter

`default_nettype wire

//--- verif/mba_partner.sv
`timescale 1ns/100ps
`default_nettype none

// One competing master plus the parallel priority resolver on the shared bus.
module mba_partner
(
	input  wire logic i_bus_clk,
	input  wire logic i_init_n,
	input  wire logic i_want,
	input  wire logic i_high,
	input  wire logic i_dut_bus_request_out_n,
	input  wire logic i_dut_busy_oe,
	input  wire logic i_dut_common_request_line_oe,
	output var  logic o_busy_n,
	output var  logic o_common_request_line_n,
	output var  logic o_prio_n
);
	logic own;

	// Both open-drain lines have pull-ups, so a released line reads high.
	assign o_busy_n = !(i_dut_busy_oe || own);
	assign o_common_request_line_n = !(i_dut_common_request_line_oe || (i_want && !own));
	assign o_prio_n = i_want && i_high;

	always_ff @(negedge i_bus_clk or negedge i_init_n)
	begin
		if (!i_init_n)
			own <= 1'h0;
		else if (!i_want)
			own <= 1'h0;
		else if (o_busy_n && (i_high || i_dut_bus_request_out_n))
			own <= 1'h1;
	end
endmodule : mba_partner

`default_nettype wire

//--- verif/mba_arbiter_tb.sv
`timescale 1ns/100ps
`default_nettype none

module mba_arbiter_tb;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic bclk = 1'h0;
	logic any = 1'h0, halt = 1'h0, transfer_acknowledge = 1'h0, want = 1'h0, high = 1'h0, preq = 1'h0;
	logic lock_n = 1'h1, init_n = 1'h1;
	logic bus_request_out_n, prio_out_n, busy_oe, common_request_line_oe, aen_n, busy_o, common_request_line_o;
	wire logic busy_n, common_request_line_n, prio_n;
	int errors = 0;
	int tests_run = 0;
	string nm [7] = '{"bus_request_out_n", "busy_oe", "aen_n", "common_request_line_oe", "prio_out_n",
		"busy_o", "common_request_line_o"};

	always #10 clk = ~clk;
	initial #7 forever #80 bclk = ~bclk;

	mba_arbiter u_dut (.i_sys_clk(clk), .i_reset(rst), .i_bus_clk(bclk), .i_busy_n(busy_n),
		.i_common_request_line_n(common_request_line_n), .i_priority_in_n(prio_n),
		.i_surrender_to_any_strap(any), .i_request_lock_in_n(lock_n), .i_init_n(init_n),
		.i_proc_request(preq), .i_proc_halt(halt), .i_transfer_acknowledge(transfer_acknowledge),
		.o_bus_request_out_n(bus_request_out_n), .o_priority_out_n(prio_out_n), .o_busy_out(busy_o),
		.o_busy_oe(busy_oe), .o_common_request_line_out(common_request_line_o),
		.o_common_request_line_oe(common_request_line_oe),
		.o_address_enable_out_n(aen_n));

	mba_partner u_far (.i_bus_clk(bclk), .i_init_n(init_n), .i_want(want), .i_high(high),
		.i_dut_bus_request_out_n(bus_request_out_n), .i_dut_busy_oe(busy_oe), .i_dut_common_request_line_oe(common_request_line_oe),
		.o_busy_n(busy_n), .o_common_request_line_n(common_request_line_n), .o_prio_n(prio_n));

	function automatic logic pick(input int k);
		case (k)
			0: return bus_request_out_n;
			1: return busy_oe;
			2: return aen_n;
			3: return common_request_line_oe;
			5: return busy_o;
			6: return common_request_line_o;
			default: return prio_out_n;
		endcase
	endfunction : pick

	task automatic end_of_test;
		$display("Checks %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test

	task automatic chk(input int k, input logic exp);
		tests_run++;
		if (pick(k) !== exp)
		begin
			errors++;
			$display("Error %s expected %b seen %b", nm[k], exp, pick(k));
		end
	endtask : chk

	task automatic wait_for(input int k, input logic exp);
		int n;
		n = 0;
		while (pick(k) !== exp && n < 200)
		begin
			@(negedge clk);
			n++;
		end
		if (pick(k) !== exp)
		begin
			errors++;
			$display("Error %s expected %b seen timeout", nm[k], exp);
			end_of_test();
		end
		chk(k, exp);
	endtask : wait_for

	task automatic hold(input int k, input logic exp, input int cyc);
		repeat (cyc)
		begin
			@(negedge clk);
			chk(k, exp);
		end
	endtask : hold

	task automatic do_reset;
		@(negedge clk);
		rst = 1'h1;
		{any, halt, transfer_acknowledge, want, high, preq} = 6'h00;
		{lock_n, init_n} = 2'h3;
		repeat (12) @(negedge clk);
		rst = 1'h0;
		repeat (16) @(negedge clk);
	endtask : do_reset

	task automatic own_bus;
		do_reset();
		preq = 1'h1;
		wait_for(0, 1'h0);
		chk(2, 1'h1);
		chk(3, 1'h1);
		chk(6, 1'h0);
		wait_for(1, 1'h1);
		chk(2, 1'h0);
		chk(3, 1'h0);
		chk(5, 1'h0);
	endtask : own_bus

	task automatic t_idle;
		do_reset();
		chk(0, 1'h1);
		chk(1, 1'h0);
		chk(2, 1'h1);
		wait_for(4, 1'h0);
	endtask : t_idle

	task automatic t_common(input logic strap);
		own_bus();
		any = strap;
		want = 1'h1;
		hold(1, 1'h1, 48);
		transfer_acknowledge = 1'h1;
		if (strap)
		begin
			wait_for(1, 1'h0);
			chk(0, 1'h1);
			chk(2, 1'h1);
		end
		else
			hold(1, 1'h1, 48);
	endtask : t_common

	task automatic t_lock;
		own_bus();
		{preq, lock_n, want} = 3'h1;
		hold(1, 1'h1, 64);
		lock_n = 1'h1;
		wait_for(1, 1'h0);
		chk(2, 1'h1);
	endtask : t_lock

	task automatic t_halt;
		own_bus();
		preq = 1'h0;
		hold(1, 1'h1, 96);
		halt = 1'h1;
		wait_for(1, 1'h0);
		chk(0, 1'h1);
	endtask : t_halt

	task automatic t_loss;
		own_bus();
		{want, high} = 2'h3;
		hold(1, 1'h1, 48);
		chk(4, 1'h1);
		transfer_acknowledge = 1'h1;
		wait_for(1, 1'h0);
	endtask : t_loss

	task automatic t_wait;
		do_reset();
		{want, high} = 2'h3;
		repeat (48) @(negedge clk);
		preq = 1'h1;
		wait_for(0, 1'h0);
		hold(2, 1'h1, 48);
		want = 1'h0;
		wait_for(1, 1'h1);
		chk(2, 1'h0);
	endtask : t_wait

	task automatic t_init;
		own_bus();
		init_n = 1'h0;
		wait_for(1, 1'h0);
		chk(2, 1'h1);
		hold(0, 1'h1, 16);
	endtask : t_init

	initial
	begin
		t_idle();
		t_common(1'h1);
		t_common(1'h0);
		t_lock();
		t_halt();
		t_loss();
		t_wait();
		t_init();
		end_of_test();
	end
endmodule : mba_arbiter_tb

`default_nettype wire
